// >>> design/cmdhd_pkg.sv
// Constants, enumerations and carriers of the charge mode decoder.
package cmdhd_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ       = 125_000_000;
  // Full-speed memorisation window, in seconds.
  localparam int unsigned FS_WINDOW_S  = 11;
  localparam logic [63:0] FS_WINDOW_CYC = 64'(FS_WINDOW_S) * 64'(CLK_HZ);
  // Output discharge after a mode change, in milliseconds.
  localparam int unsigned DISCHARGE_MS = 2000;
  localparam logic [63:0] DISCHARGE_CYC =
    (64'(DISCHARGE_MS) * 64'(CLK_HZ)) / 64'h3E8;

  // ==========================================================================
  // Register map (byte addresses) and fields
  // ==========================================================================
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [11:0] PINS_OFS      = 12'h008;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_AWAKE_BIT = 1;
  localparam logic        CTRL_EN_RST    = 1'h0;
  localparam logic        CTRL_AWAKE_RST = 1'h0;
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_HID_LSB    = 4;
  localparam int unsigned ST_DSW_BIT    = 8;
  localparam int unsigned ST_DIS_BIT    = 9;
  localparam int unsigned ST_LOAD_BIT   = 10;
  localparam int unsigned ST_LIM_LSB    = 12;
  localparam int unsigned PINS_SEL_LSB  = 0;
  localparam int unsigned PINS_SNS_LSB  = 4;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    MODE_DISCHARGE, MODE_DEDICATED_AUTO, MODE_STANDARD_ONE,
    MODE_DEDICATED_SHORTED, MODE_DIVIDER_LOW, MODE_STANDARD_TWO,
    MODE_CHARGING_DOWN
  } cmdhd_mode_t;

  typedef enum logic [1:0] {
    LIMIT_NONE, LIMIT_LOW, LIMIT_HIGH, LIMIT_POWER_WAKE
  } cmdhd_limit_t;

  typedef enum logic [2:0] {
    HID_NONE, HID_LOW_SPEED, HID_FS_WAIT, HID_FULL_SPEED, HID_HIGH_SPEED
  } cmdhd_hid_t;

  localparam cmdhd_mode_t MODE_RST = MODE_DISCHARGE;
  localparam cmdhd_hid_t  HID_RST  = HID_NONE;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic mode_select_a;
    logic mode_select_b;
    logic mode_select_c;
    logic limit_select;
  } cmdhd_sel_t;

  localparam cmdhd_sel_t SEL_RST = 4'h0;

  typedef struct packed {
    logic dp;
    logic dm;
    logic load_non_pw;
    logic load_pw;
    logic bc_primary;
  } cmdhd_sense_t;

  typedef struct packed {
    cmdhd_limit_t limit;
    logic         data_switch_on;
    logic         out_discharge;
    logic         load_present_n;
    logic         hid_low_speed;
    logic         hid_full_speed;
  } cmdhd_port_t;

  localparam cmdhd_port_t PORT_RST = {LIMIT_NONE, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};

endpackage : cmdhd_pkg

// >>> design/cmdhd_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none

module cmdhd_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pin side and clock side.
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } cmdhd_sync_st_t;

  cmdhd_sync_st_t st_q;
  cmdhd_sync_st_t st_d;

  if (WIDTH < 1) begin : g_chk
    $error("cmdhd_sync: WIDTH must be at least one.");
  end

  // The first stage feeds only the second one, so metastability stays inside.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule : cmdhd_sync

`default_nettype wire

// >>> design/cmdhd_decoder.sv
// Charge mode decoder with low/full-speed HID recognition and an APB port.
//
// Functional notes
// - Detect low/full-speed attach only in standard or charging downstream modes.
// - Both lines low is no device; D- high low speed; D+ high full speed.
// - Watch both lines in those modes; settle HID type only while awake.
// - A D+ drop after connect marks high speed, not full speed.
// - Full speed recognised after 11 s connected while awake.
// - Low speed is recognised at once, with no window.
// - Mode pin changes carry no timing constraint around a wake.
// - Follow mode pins always, except a change to 011 from a downstream mode while a HID device is held.
// - Pattern 000 is discharge: output held low, load-present off.
// - 010 and 110 give standard mode one, limit by select.
// - 100 forces shorted dedicated mode, limit by select, lines open.
// - 101 forces divider mode, limit by select.
// - 1110 standard mode two low limit; 1111 charging downstream high limit.
// - In 1111 load-present asserts on load or primary detection.
// - No output discharge on a change between 1111 and 1110.
// - a=0, c=1 is dedicated auto, high limit, lines open, load sense if select.
// - In 0011 the limit follows power-wake load detection.
// - With a HID held, ignore a change from 111, 110 or 010 to 011.
// - Switches close only in downstream modes with enable, not discharging.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module cmdhd_decoder #(
  parameter int unsigned FS_WINDOW_CYCLES = 32'(cmdhd_pkg::FS_WINDOW_CYC),
  parameter int unsigned DISCHARGE_CYCLES = 32'(cmdhd_pkg::DISCHARGE_CYC)
) (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // Pins from the system controller and the port sense circuits.
  input  wire cmdhd_pkg::cmdhd_sel_t   mode_pins,
  input  wire cmdhd_pkg::cmdhd_sense_t sense_pins,
  // Port control outputs.
  output var  cmdhd_pkg::cmdhd_port_t  port
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  if (FS_WINDOW_CYCLES < 2) begin : g_chk_fs
    $error("cmdhd_decoder: FS_WINDOW_CYCLES must be at least two.");
  end
  if (DISCHARGE_CYCLES < 1) begin : g_chk_dis
    $error("cmdhd_decoder: DISCHARGE_CYCLES must be at least one.");
  end

  localparam logic [31:0] FS_LAST  = 32'(FS_WINDOW_CYCLES - 1);
  localparam logic [31:0] DIS_LOAD = 32'(DISCHARGE_CYCLES);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  cmdhd_pkg::cmdhd_sel_t   sel_s;
  cmdhd_pkg::cmdhd_sense_t sns_s;

  // Mode pins cross into the clock domain first.
  cmdhd_sync #(.WIDTH(4)) u_sync_sel (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (mode_pins),
    .sync_out (sel_s)
  );

  // Data lines and load sense comparators are asynchronous too.
  cmdhd_sync #(.WIDTH(5)) u_sync_sns (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sense_pins),
    .sync_out (sns_s)
  );

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Maps a pin pattern onto a charging mode.
  function automatic cmdhd_pkg::cmdhd_mode_t decode(input cmdhd_pkg::cmdhd_sel_t s);
    cmdhd_pkg::cmdhd_mode_t m;
    m = cmdhd_pkg::MODE_DISCHARGE;
    if (!s.mode_select_a) begin
      if (s.mode_select_c) begin
        m = cmdhd_pkg::MODE_DEDICATED_AUTO;
      end else if (s.mode_select_b) begin
        m = cmdhd_pkg::MODE_STANDARD_ONE;
      end else begin
        m = cmdhd_pkg::MODE_DISCHARGE;
      end
    end else if (!s.mode_select_b) begin
      m = s.mode_select_c ? cmdhd_pkg::MODE_DIVIDER_LOW
                          : cmdhd_pkg::MODE_DEDICATED_SHORTED;
    end else if (!s.mode_select_c) begin
      m = cmdhd_pkg::MODE_STANDARD_ONE;
    end else begin
      m = s.limit_select ? cmdhd_pkg::MODE_CHARGING_DOWN
                         : cmdhd_pkg::MODE_STANDARD_TWO;
    end
    return m;
  endfunction : decode

  // True for the modes in which the data lines reach the host.
  function automatic logic is_downstream(input cmdhd_pkg::cmdhd_mode_t m);
    return (m == cmdhd_pkg::MODE_STANDARD_ONE) ||
           (m == cmdhd_pkg::MODE_STANDARD_TWO) ||
           (m == cmdhd_pkg::MODE_CHARGING_DOWN);
  endfunction : is_downstream

  // True for the two modes that share a port without discharge.
  function automatic logic is_pair(input cmdhd_pkg::cmdhd_mode_t m);
    return (m == cmdhd_pkg::MODE_STANDARD_TWO) ||
           (m == cmdhd_pkg::MODE_CHARGING_DOWN);
  endfunction : is_pair

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    cmdhd_pkg::cmdhd_sel_t  prev;
    cmdhd_pkg::cmdhd_sel_t  sel;
    cmdhd_pkg::cmdhd_mode_t mode;
    cmdhd_pkg::cmdhd_hid_t  hid;
    logic [31:0]            fs_cnt;
    logic [31:0]            dis_cnt;
    logic                   ctrl_en;
    logic                   ctrl_awake;
    logic [31:0]            rdata;
    cmdhd_pkg::cmdhd_port_t port;
  } cmdhd_st_t;

  localparam cmdhd_st_t ST_RST = '{
    prev:       cmdhd_pkg::SEL_RST,
    sel:        cmdhd_pkg::SEL_RST,
    mode:       cmdhd_pkg::MODE_RST,
    hid:        cmdhd_pkg::HID_RST,
    fs_cnt:     32'h0000_0000,
    dis_cnt:    32'h0000_0000,
    ctrl_en:    cmdhd_pkg::CTRL_EN_RST,
    ctrl_awake: cmdhd_pkg::CTRL_AWAKE_RST,
    rdata:      32'h0000_0000,
    port:       cmdhd_pkg::PORT_RST
  };

  cmdhd_st_t st_q;
  cmdhd_st_t st_d;

  // ==========================================================================
  // Combinational helpers
  // ==========================================================================
  logic                   stable;
  logic                   hid_held;
  logic                   to_auto_b;
  logic                   blocked;
  logic                   monitor;
  logic                   discharging;
  logic                   load_hit;
  logic                   map_hit;
  logic                   wr_en;
  logic                   rd_setup;
  cmdhd_pkg::cmdhd_mode_t new_mode;
  cmdhd_pkg::cmdhd_limit_t lim;

  // Act on a pin pattern only once it repeats.
  assign stable    = (sel_s == st_q.prev);
  assign new_mode  = decode(sel_s);
  assign hid_held  = (st_q.hid == cmdhd_pkg::HID_LOW_SPEED) ||
                     (st_q.hid == cmdhd_pkg::HID_FULL_SPEED);
  assign to_auto_b = !sel_s.mode_select_a && sel_s.mode_select_b && sel_s.mode_select_c;
  // A held HID keeps the data path so the device can wake the host.
  assign blocked   = hid_held && is_downstream(st_q.mode) && to_auto_b;
  assign monitor   = is_downstream(st_q.mode);
  assign discharging = (st_q.mode == cmdhd_pkg::MODE_DISCHARGE) ||
                       (st_q.dis_cnt != 32'h0000_0000);

  // APB decode; the slave never stretches a transfer.
  assign map_hit  = (paddr == cmdhd_pkg::CTRL_OFS) ||
                    (paddr == cmdhd_pkg::STATUS_OFS) ||
                    (paddr == cmdhd_pkg::PINS_OFS);
  assign wr_en    = psel && penable && pwrite && map_hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !map_hit;

  // Current limit and load-present for the applied mode.
  always_comb begin
    lim      = cmdhd_pkg::LIMIT_NONE;
    load_hit = 1'b0;
    unique case (st_q.mode)
      cmdhd_pkg::MODE_DISCHARGE: begin
        lim = cmdhd_pkg::LIMIT_NONE;
      end
      cmdhd_pkg::MODE_DEDICATED_AUTO: begin
        if (!st_q.sel.mode_select_b && st_q.sel.limit_select) begin
          // Small limit keeps a standby supply alive until a load appears.
          lim = sns_s.load_pw ? cmdhd_pkg::LIMIT_HIGH
                              : cmdhd_pkg::LIMIT_POWER_WAKE;
          load_hit = sns_s.load_pw;
        end else begin
          lim      = cmdhd_pkg::LIMIT_HIGH;
          load_hit = st_q.sel.limit_select && sns_s.load_non_pw;
        end
      end
      cmdhd_pkg::MODE_STANDARD_ONE,
      cmdhd_pkg::MODE_DEDICATED_SHORTED,
      cmdhd_pkg::MODE_DIVIDER_LOW: begin
        lim = st_q.sel.limit_select ? cmdhd_pkg::LIMIT_HIGH
                                    : cmdhd_pkg::LIMIT_LOW;
      end
      cmdhd_pkg::MODE_STANDARD_TWO: begin
        lim = cmdhd_pkg::LIMIT_LOW;
      end
      cmdhd_pkg::MODE_CHARGING_DOWN: begin
        lim      = cmdhd_pkg::LIMIT_HIGH;
        load_hit = sns_s.load_non_pw || sns_s.bc_primary;
      end
      default: begin
        lim      = cmdhd_pkg::LIMIT_NONE;
        load_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_d      = st_q;
    st_d.prev = sel_s;

    // Count the discharge down; a fresh mode change below reloads it.
    if (st_q.dis_cnt != 32'h0000_0000) begin
      st_d.dis_cnt = st_q.dis_cnt - 32'h0000_0001;
    end

    // Follow the pins at any time, with no setup window after a wake.
    if (stable && !blocked && (sel_s != st_q.sel)) begin
      st_d.sel  = sel_s;
      st_d.mode = new_mode;
      if ((new_mode != st_q.mode) && !(is_pair(new_mode) && is_pair(st_q.mode))) begin
        st_d.dis_cnt = DIS_LOAD;
      end
    end
    // HID recognition; the type is only settled while the host is awake.
    unique case (st_q.hid)
      cmdhd_pkg::HID_NONE: begin
        if (monitor && st_q.ctrl_awake) begin
          if (sns_s.dm && !sns_s.dp) begin
            st_d.hid = cmdhd_pkg::HID_LOW_SPEED;
          end else if (sns_s.dp && !sns_s.dm) begin
            st_d.hid    = cmdhd_pkg::HID_FS_WAIT;
            st_d.fs_cnt = 32'h0000_0000;
          end
        end
      end
      cmdhd_pkg::HID_LOW_SPEED,
      cmdhd_pkg::HID_FULL_SPEED: begin
        // Held through sleep; only a seen disconnect while awake drops it.
        if (monitor && st_q.ctrl_awake && !sns_s.dp && !sns_s.dm) begin
          st_d.hid = cmdhd_pkg::HID_NONE;
        end
      end
      cmdhd_pkg::HID_FS_WAIT: begin
        if (!(monitor && st_q.ctrl_awake)) begin
          st_d.hid = cmdhd_pkg::HID_NONE;
        end else if (!sns_s.dp) begin
          st_d.hid = cmdhd_pkg::HID_HIGH_SPEED;
        end else if (st_q.fs_cnt == FS_LAST) begin
          st_d.hid = cmdhd_pkg::HID_FULL_SPEED;
        end else begin
          st_d.fs_cnt = st_q.fs_cnt + 32'h0000_0001;
        end
      end
      cmdhd_pkg::HID_HIGH_SPEED: begin
        // A high-speed device is never a wake source; forget it on leaving.
        if (!monitor) begin
          st_d.hid = cmdhd_pkg::HID_NONE;
        end
      end
      default: begin
        st_d.hid = cmdhd_pkg::HID_NONE;
      end
    endcase

    // Software writes take effect in the access phase.
    if (wr_en && (paddr == cmdhd_pkg::CTRL_OFS)) begin
      st_d.ctrl_en    = pwdata[cmdhd_pkg::CTRL_EN_BIT];
      st_d.ctrl_awake = pwdata[cmdhd_pkg::CTRL_AWAKE_BIT];
    end

    // Read data is captured at setup so it stands through the access.
    if (rd_setup) begin
      st_d.rdata = 32'h0000_0000;
      unique case (paddr)
        cmdhd_pkg::CTRL_OFS: begin
          st_d.rdata[cmdhd_pkg::CTRL_EN_BIT]    = st_q.ctrl_en;
          st_d.rdata[cmdhd_pkg::CTRL_AWAKE_BIT] = st_q.ctrl_awake;
        end
        cmdhd_pkg::STATUS_OFS: begin
          st_d.rdata[cmdhd_pkg::ST_MODE_LSB +: 3] = st_q.mode;
          st_d.rdata[cmdhd_pkg::ST_HID_LSB +: 3]  = st_q.hid;
          st_d.rdata[cmdhd_pkg::ST_DSW_BIT]       = st_q.port.data_switch_on;
          st_d.rdata[cmdhd_pkg::ST_DIS_BIT]       = st_q.port.out_discharge;
          st_d.rdata[cmdhd_pkg::ST_LOAD_BIT]      = !st_q.port.load_present_n;
          st_d.rdata[cmdhd_pkg::ST_LIM_LSB +: 2]  = st_q.port.limit;
        end
        cmdhd_pkg::PINS_OFS: begin
          st_d.rdata[cmdhd_pkg::PINS_SEL_LSB +: 4] = st_q.sel;
          st_d.rdata[cmdhd_pkg::PINS_SNS_LSB +: 5] = sns_s;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Registered port outputs.
    st_d.port.limit          = lim;
    st_d.port.out_discharge  = discharging;
    st_d.port.data_switch_on = monitor && st_q.ctrl_en && !discharging;
    st_d.port.load_present_n = !(load_hit && !discharging);
    st_d.port.hid_low_speed  = (st_q.hid == cmdhd_pkg::HID_LOW_SPEED);
    st_d.port.hid_full_speed = (st_q.hid == cmdhd_pkg::HID_FULL_SPEED);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign port   = st_q.port;

endmodule : cmdhd_decoder

`default_nettype wire

// >>> verif/cmdhd_usb_dev.sv
// Behavioural model of the attached USB device and the port load sensors.
`timescale 1ns/100ps
`default_nettype none

module cmdhd_usb_dev #(
  parameter int unsigned HS_UP = 5
) (
  // Clock.
  input  wire logic                    pclk,
  // Device kind (0 none, 1 low, 2 full, 3 high speed) and loads {non_pw, pw, bc}.
  input  wire logic [1:0]              kind,
  input  wire logic [2:0]              loads,
  // Lines and sensors seen by the block.
  output var  cmdhd_pkg::cmdhd_sense_t sense
);
  // ==========================================================================
  // Line levels
  // ==========================================================================
  logic [7:0] up_q = 8'h00;

  // Cycles since a high-speed connect; its pull-up goes away after HS_UP.
  always_ff @(posedge pclk) begin
    up_q <= (kind == 2'h3 && up_q != 8'hFF) ? up_q + 8'h01 : 8'h00;
  end

  // Host pull-downs keep both lines low when nothing is attached.
  always_comb begin
    sense.dp = (kind == 2'h2) || (kind == 2'h3 && up_q < 8'(HS_UP));
    sense.dm = (kind == 2'h1);
    {sense.load_non_pw, sense.load_pw, sense.bc_primary} = loads;
  end
endmodule : cmdhd_usb_dev
`default_nettype wire

// >>> verif/cmdhd_decoder_asserts.sv
// Concurrent checks on the pins of the charge mode decoder.
`timescale 1ns/100ps
`default_nettype none

module cmdhd_decoder_asserts #(
  parameter int unsigned FS_WINDOW_CYCLES = 20
) (
  // Clock and reset.
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB.
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pslverr,
  // Pins and port outputs.
  input wire cmdhd_pkg::cmdhd_sel_t   mode_pins,
  input wire cmdhd_pkg::cmdhd_sense_t sense_pins,
  input wire cmdhd_pkg::cmdhd_port_t  port
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic       awake_q;
  logic [9:0] vec_q;
  logic [3:0] stab_q;
  logic [3:0] abc_q;
  logic [2:0] abc_old_q;
  logic [7:0] dp_q;
  wire logic [9:0] vec = {mode_pins, sense_pins, awake_q};
  wire logic [2:0] abc = mode_pins[3:1];
  wire logic       calm    = vec == vec_q && stab_q >= 4'h5;
  wire logic       settled = calm && !port.out_discharge;

  // Stability counters gate checks until pins have crossed in.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      awake_q <= 1'b0;
      vec_q <= 10'h000;
      stab_q <= 4'h0;
      abc_q <= 4'h0;
      abc_old_q <= 3'h0;
      dp_q <= 8'h00;
    end else begin
      if (psel && penable && pwrite && paddr == cmdhd_pkg::CTRL_OFS) begin
        awake_q <= pwdata[cmdhd_pkg::CTRL_AWAKE_BIT];
      end
      vec_q <= vec;
      stab_q <= (vec != vec_q) ? 4'h0 : stab_q + {3'h0, stab_q != 4'hF};
      abc_old_q <= abc;
      abc_q <= (abc != abc_old_q) ? 4'h0 : abc_q + {3'h0, abc_q != 4'hF};
      dp_q <= !sense_pins.dp ? 8'h00 : dp_q + {7'h0, dp_q != 8'hFF};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DISCH_IDLE: assert property (
    calm && abc == 3'h0 |-> port.out_discharge && port.load_present_n)
    else $error("idle pattern not discharging");
  AST_SWITCH_OPEN: assert property (
    port.data_switch_on |-> !port.out_discharge && $past(abc, 5) != 3'h0)
    else $error("switch closed in discharge");
  AST_LIMIT_FIXED: assert property (
    settled && abc != 3'h0 && (abc[2] || !abc[0]) |-> port.limit ==
    (mode_pins.limit_select ? cmdhd_pkg::LIMIT_HIGH : cmdhd_pkg::LIMIT_LOW))
    else $error("limit not per select");
  AST_AUTO_LIMIT: assert property (
    settled && abc == 3'h1 |-> !port.data_switch_on && port.limit ==
    ((mode_pins.limit_select && !sense_pins.load_pw) ? cmdhd_pkg::LIMIT_POWER_WAKE
    : cmdhd_pkg::LIMIT_HIGH) && port.load_present_n == !(mode_pins.limit_select && sense_pins.load_pw))
    else $error("auto mode output wrong");
  AST_CDP_LOAD: assert property (
    settled && mode_pins == 4'hF |->
    port.load_present_n == !(sense_pins.load_non_pw || sense_pins.bc_primary))
    else $error("downstream load output wrong");
  AST_NO_DIS: assert property (
    $rose(port.out_discharge) && abc == 3'h7 |-> abc_q < 4'h6)
    else $error("discharge between top modes");
  AST_SLVERR: assert property (
    psel && penable |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("error response wrong");
  AST_LOW_SPEED: assert property (
    calm && awake_q && (abc == 3'h7 || abc[1:0] == 2'h2) && sense_pins.dm &&
    !sense_pins.dp && !port.hid_full_speed |-> port.hid_low_speed)
    else $error("low speed device not recognised");
  AST_FS_WINDOW: assert property (
    $rose(port.hid_full_speed) |-> dp_q >= 8'(FS_WINDOW_CYCLES))
    else $error("full speed recognised early");
endmodule : cmdhd_decoder_asserts

bind cmdhd_decoder cmdhd_decoder_asserts #(.FS_WINDOW_CYCLES(FS_WINDOW_CYCLES)) chk_u (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .mode_pins, .sense_pins,
  .port);
`default_nettype wire

// >>> verif/test_charge_mode_decoder_hid_detect.sv
// Self-checking bench of the charge mode decoder.
`timescale 1ns/100ps
`default_nettype none

module test_charge_mode_decoder_hid_detect;
  // Short windows keep the run brief.
  localparam int unsigned FS = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] kind;
  logic [2:0] loads;
  int num_errors, checked, cycles;
  cmdhd_pkg::cmdhd_sel_t   mode_pins;
  cmdhd_pkg::cmdhd_sense_t sense_pins;
  cmdhd_pkg::cmdhd_port_t  port;

  cmdhd_decoder #(.FS_WINDOW_CYCLES(FS), .DISCHARGE_CYCLES(8)) dut_u (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_pins,
    .sense_pins, .port);
  cmdhd_usb_dev #(.HS_UP(5)) dev_u (.pclk, .kind, .loads, .sense(sense_pins));

  // ==========================================================================
  // Clock, watchdog and tasks
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Pins and device change on an edge; sampling is at the falling edge.
  task automatic put(input logic [3:0] v, input logic [1:0] k, input logic [2:0] l, input int n);
    @(posedge pclk);
    mode_pins <= v;
    kind <= k;
    loads <= l;
    cyc(n);
    @(negedge pclk);
  endtask : put

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic cmdhd_pkg::cmdhd_port_t exp_port(input logic [3:0] p, input logic en,
    input logic [2:0] ld);
    cmdhd_pkg::cmdhd_port_t e;
    e = {p[0] ? cmdhd_pkg::LIMIT_HIGH : cmdhd_pkg::LIMIT_LOW, en, 4'h4};
    if (p[3:1] == 3'h0) e = cmdhd_pkg::PORT_RST;
    else if (!p[3] && p[1]) begin
      e.limit = (!p[2] && p[0] && !ld[1]) ? cmdhd_pkg::LIMIT_POWER_WAKE : cmdhd_pkg::LIMIT_HIGH;
      e.data_switch_on = 1'b0;
      e.load_present_n = !(p[0] && (p[2] ? ld[2] : ld[1]));
    end else if (p[3:2] == 2'h2) e.data_switch_on = 1'b0;
    else if (p[3:1] == 3'h7) e.load_present_n = !(p[0] && (ld[2] || ld[0]));
    return e;
  endfunction : exp_port

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, kind, loads} = '0;
    mode_pins = cmdhd_pkg::SEL_RST;
    {num_errors, checked, cycles} = '0;
    cyc(2);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'(port), 32'(cmdhd_pkg::PORT_RST));
    apb(1'b0, 12'hFFC, 32'h0);
    check({31'h0, err & pready}, 32'h1);
    check(rd, 32'h0);
    $display("reset test done");
    // Every pin pattern, with and without enable and loads.
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, {31'h0, p == 0});
      for (int i = 0; i < 16; i++) begin
        put(i[3:0], 2'h0, {3{p[0]}}, 20);
        check(32'(port), 32'(exp_port(i[3:0], p == 0, {3{p[0]}})));
      end
    end
    $display("truth table test done");
    // Device recognition, refused auto change, window and awake gating.
    apb(1'b1, 12'h000, 32'h3);
    put(4'hF, 2'h1, 3'h0, 20);
    check(32'(port.hid_low_speed), 32'h1);
    put(4'h7, 2'h1, 3'h0, 20);
    check(32'(port.data_switch_on), 32'h1);
    put(4'hF, 2'h0, 3'h0, 20);
    check(32'(port.hid_low_speed), 32'h0);
    put(4'hF, 2'h2, 3'h0, 10);
    check(32'(port.hid_full_speed), 32'h0);
    put(4'hF, 2'h2, 3'h0, FS + 10);
    check(32'(port.hid_full_speed), 32'h1);
    put(4'hF, 2'h0, 3'h0, 20);
    put(4'hF, 2'h3, 3'h0, FS + 20);
    check(32'(port.hid_full_speed), 32'h0);
    put(4'h3, 2'h0, 3'h0, 20);
    apb(1'b1, 12'h000, 32'h1);
    put(4'hF, 2'h1, 3'h0, 20);
    check(32'(port.hid_low_speed), 32'h0);
    put(4'h3, 2'h1, 3'h0, 20);
    apb(1'b1, 12'h000, 32'h3);
    put(4'h3, 2'h1, 3'h0, 20);
    check(32'(port.hid_low_speed), 32'h0);
    $display("device test done");
    // Discharge only on a real mode change.
    put(4'hF, 2'h0, 3'h0, 20);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rd[2:0]), 32'(cmdhd_pkg::MODE_CHARGING_DOWN));
    put(4'hE, 2'h0, 3'h0, 0);
    repeat (8) begin
      @(negedge pclk);
      check(32'(port.out_discharge), 32'h0);
    end
    put(4'h6, 2'h0, 3'h0, 6);
    check(32'(port.out_discharge), 32'h1);
    $display("discharge test done");
    test_done();
  end
endmodule : test_charge_mode_decoder_hid_detect
`default_nettype wire
